/* File: hw/ctc_cache_tag_controller.sv */
`timescale 1ns/1ps
// Overview of operation
// - after reset every data location is cleared to zero before any access.
// - each read compares high address bits with the tag at the indexed entry.
// - differing tag bits drive the match output low, a miss.
// - a miss requests memory and holds the processor waiting until data arrives.
// - fetched memory data is also written into the data cache.
// - an equal tag on a filled entry drives match high, meaning the cached data is valid.
// - a read hit returns cached data and completes without any wait state.
// - direct mapped: the index bits pick exactly one cache location.
// - set associative option: two or four tag and data banks, shared control.
// - the refilled bank is an empty one if any, else the one after the most recently read.
module ctc_cache_tag_controller
   import ctc_pkg::*;
#(
   parameter int WAYS = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // processor side
   input wire ctc_cpu_req_type cpu_req,
   output logic [CTC_DATA_W-1:0] cpu_rdata,
   output logic cpu_done,
   output logic cpu_wait,
   output logic cpu_match,
   output logic init_busy,
   // main memory side
   output ctc_mem_req_type mem_req,
   input wire logic mem_ack,
   input wire logic [CTC_DATA_W-1:0] mem_rdata
);

   // width of a bank number, at least one bit
   localparam int WAY_W = (WAYS > 1) ? $clog2(WAYS) : 1;

   // lowest set bit of a way vector as a way number
   function automatic logic [WAY_W-1:0] way_of(input logic [WAYS-1:0] v);
      logic [WAY_W-1:0] w;
      w = '0;
      for (int i = WAYS - 1; i >= 0; i--) begin
         if (v[i]) begin
            w = WAY_W'(i);
         end
      end
      return w;
   endfunction

   // bank number as a one-hot write select
   function automatic logic [WAYS-1:0] way_sel(input logic [WAY_W-1:0] w);
      logic [WAYS-1:0] s;
      s = '0;
      for (int i = 0; i < WAYS; i++) begin
         if (WAY_W'(i) == w) begin
            s[i] = 1'b1;
         end
      end
      return s;
   endfunction

   // tag banks, data banks, fill flags and recency store
   logic [CTC_DATA_W-1:0] data_mem [WAYS][CTC_SETS];
   logic [CTC_TAG_W-1:0] tag_mem [WAYS][CTC_SETS];
   logic [CTC_SETS-1:0] valid_mem [WAYS];
   logic [WAY_W-1:0] lru_mem [CTC_SETS];

   // control state
   ctc_state_type state_reg;
   ctc_state_type state_next;
   ctc_cpu_req_type req_reg;
   ctc_cpu_req_type req_next;

   // sweep position
   logic [CTC_INDEX_W-1:0] init_cnt_reg;
   logic [CTC_INDEX_W-1:0] init_cnt_next;

   // registered processor and memory outputs
   logic [CTC_DATA_W-1:0] rdata_reg;
   logic [CTC_DATA_W-1:0] rdata_next;
   logic done_reg;
   logic done_next;
   logic wait_reg;
   logic wait_next;
   logic match_reg;
   logic match_next;
   logic busy_reg;
   logic busy_next;
   ctc_mem_req_type mem_req_reg;
   ctc_mem_req_type mem_req_next;

   // array write controls
   logic clr_all;
   logic arr_we;
   logic [WAY_W-1:0] arr_way;
   logic [CTC_INDEX_W-1:0] arr_idx;
   logic [CTC_DATA_W-1:0] arr_data;
   logic [WAYS-1:0] arr_sel;
   logic lru_we;
   logic [WAY_W-1:0] lru_val;

   // lookup signals
   ctc_cpu_req_type look;
   logic [CTC_INDEX_W-1:0] look_idx;
   logic [CTC_TAG_W-1:0] look_tag;
   logic [WAYS-1:0] hit_vec;
   logic [WAYS-1:0] inv_vec;
   logic hit_any;
   logic [WAY_W-1:0] hit_way;
   logic [WAY_W-1:0] victim;

   // new requests look up directly, a pending one from its register
   assign look = (state_reg == ST_IDLE) ? cpu_req : req_reg;
   assign look_idx = look.addr[CTC_INDEX_W-1:0];
   assign look_tag = look.addr[CTC_ADDR_W-1:CTC_TAG_LSB];

   // one comparator per bank, all on the same index
   genvar g;
   generate
      for (g = 0; g < WAYS; g++) begin : gen_way
         ctc_tag_cmp #(
            .TAG_W(CTC_TAG_W)
         ) u_cmp (
            .stored_tag(tag_mem[g][look_idx]),
            .stored_valid(valid_mem[g][look_idx]),
            .addr_tag(look_tag),
            .match(hit_vec[g])
         );
         assign inv_vec[g] = ~valid_mem[g][look_idx];
      end
   endgenerate

   // any bank hit, and the lowest bank that did
   assign hit_any = |hit_vec;
   assign hit_way = way_of(hit_vec);

   // bank select for array writes
   assign arr_sel = way_sel(arr_way);

   // empty bank first, else the one after the most recently read
   always_comb begin
      if (|inv_vec) begin
         victim = way_of(inv_vec);
      end else begin
         victim = WAY_W'((int'(lru_mem[look_idx]) + 1) % WAYS);
      end
   end

   // next state of the controller
   always_comb begin
      state_next = state_reg;
      req_next = req_reg;
      init_cnt_next = init_cnt_reg;
      rdata_next = rdata_reg;
      done_next = 1'b0;
      wait_next = wait_reg;
      match_next = match_reg;
      busy_next = busy_reg;
      mem_req_next = mem_req_reg;
      clr_all = 1'b0;
      arr_we = 1'b0;
      arr_way = '0;
      arr_idx = look_idx;
      arr_data = CTC_DATA_CLEAR;
      lru_we = 1'b0;
      lru_val = '0;
      case (state_reg)
         ST_INIT: begin
            // sweep all sets, processor held off meanwhile
            clr_all = 1'b1;
            arr_idx = init_cnt_reg;
            init_cnt_next = CTC_INDEX_W'(init_cnt_reg + 1'b1);
            if (init_cnt_reg == CTC_INIT_LAST) begin
               state_next = ST_IDLE;
               busy_next = 1'b0;
               wait_next = 1'b0;
            end
         end
         ST_IDLE: begin
            if (cpu_req.valid) begin
               req_next = cpu_req;
               match_next = hit_any;
               if (!cpu_req.write) begin
                  if (hit_any) begin
                     // served from the bank, no wait state
                     rdata_next = data_mem[hit_way][look_idx];
                     done_next = 1'b1;
                     lru_we = 1'b1;
                     lru_val = hit_way;
                  end else begin
                     // fetch from main memory and hold the processor
                     mem_req_next = '{req: 1'b1, write: 1'b0, addr: cpu_req.addr,
                                      wdata: CTC_DATA_CLEAR};
                     wait_next = 1'b1;
                     state_next = ST_FILL;
                  end
               end else begin
                  // write through; a resident copy is updated as well
                  mem_req_next = '{req: 1'b1, write: 1'b1, addr: cpu_req.addr,
                                   wdata: cpu_req.wdata};
                  wait_next = 1'b1;
                  state_next = ST_WRITE;
                  if (hit_any) begin
                     arr_we = 1'b1;
                     arr_way = hit_way;
                     arr_data = cpu_req.wdata;
                  end
               end
            end
         end
         ST_FILL: begin
            if (mem_ack) begin
               // refill the chosen bank with data and tag
               arr_we = 1'b1;
               arr_way = victim;
               arr_data = mem_rdata;
               lru_we = 1'b1;
               lru_val = victim;
               rdata_next = mem_rdata;
               done_next = 1'b1;
               wait_next = 1'b0;
               mem_req_next = CTC_MEM_REQ_RESET;
               state_next = ST_IDLE;
            end
         end
         ST_WRITE: begin
            // memory took the word, release the processor
            if (mem_ack) begin
               done_next = 1'b1;
               wait_next = 1'b0;
               mem_req_next = CTC_MEM_REQ_RESET;
               state_next = ST_IDLE;
            end
         end
         default: begin
            // unknown state: restart the sweep with the processor held off
            state_next = ST_INIT;
            init_cnt_next = CTC_INIT_FIRST;
            busy_next = 1'b1;
            wait_next = 1'b1;
            mem_req_next = CTC_MEM_REQ_RESET;
         end
      endcase
   end

   // control registers
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_reg <= ST_INIT;
         req_reg <= CTC_CPU_REQ_RESET;
         init_cnt_reg <= CTC_INIT_FIRST;
         rdata_reg <= CTC_DATA_CLEAR;
         done_reg <= 1'b0;
         wait_reg <= 1'b1;
         match_reg <= 1'b0;
         busy_reg <= 1'b1;
         mem_req_reg <= CTC_MEM_REQ_RESET;
      end else begin
         state_reg <= state_next;
         req_reg <= req_next;
         init_cnt_reg <= init_cnt_next;
         rdata_reg <= rdata_next;
         done_reg <= done_next;
         wait_reg <= wait_next;
         match_reg <= match_next;
         busy_reg <= busy_next;
         mem_req_reg <= mem_req_next;
      end
   end

   // tag, data and fill-flag banks
   always_ff @(posedge clock) begin
      if (clr_all) begin
         for (int w = 0; w < WAYS; w++) begin
            data_mem[w][arr_idx] <= CTC_DATA_CLEAR;
            valid_mem[w][arr_idx] <= 1'b0;
         end
      end else if (arr_we) begin
         for (int w = 0; w < WAYS; w++) begin
            if (arr_sel[w]) begin
               data_mem[w][arr_idx] <= arr_data;
               tag_mem[w][arr_idx] <= look_tag;
               valid_mem[w][arr_idx] <= 1'b1;
            end
         end
      end
   end

   // recency store, one entry per set
   always_ff @(posedge clock) begin
      if (clr_all) begin
         lru_mem[arr_idx] <= '0;
      end else if (lru_we) begin
         lru_mem[look_idx] <= lru_val;
      end
   end

   // outputs straight from registers
   assign cpu_rdata = rdata_reg;
   assign cpu_done = done_reg;
   assign cpu_wait = wait_reg;
   assign cpu_match = match_reg;
   assign init_busy = busy_reg;
   assign mem_req = mem_req_reg;
endmodule

/* File: hw/ctc_pkg.sv */
package ctc_pkg;

   // address split and data width
   localparam int CTC_ADDR_W = 24;
   localparam int CTC_DATA_W = 16;
   localparam int CTC_INDEX_W = 12;
   localparam int CTC_TAG_W = CTC_ADDR_W - CTC_INDEX_W;
   localparam int CTC_SETS = 1 << CTC_INDEX_W;

   // position of the tag field inside the address
   localparam int CTC_TAG_LSB = CTC_INDEX_W;

   // power-up sweep runs over every set, last index ends it
   localparam logic [CTC_INDEX_W-1:0] CTC_INIT_FIRST = 12'h000;
   localparam logic [CTC_INDEX_W-1:0] CTC_INIT_LAST = 12'hFFF;

   // value written into every data location during the sweep
   localparam logic [CTC_DATA_W-1:0] CTC_DATA_CLEAR = 16'h0000;

   // controller states
   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_IDLE = 2'b01,
      ST_FILL = 2'b10,
      ST_WRITE = 2'b11
   } ctc_state_type;

   // processor request, sampled in the cycle valid is high
   typedef struct packed {
      logic valid;
      logic write;
      logic [CTC_ADDR_W-1:0] addr;
      logic [CTC_DATA_W-1:0] wdata;
   } ctc_cpu_req_type;

   // request to main memory, held until acknowledged
   typedef struct packed {
      logic req;
      logic write;
      logic [CTC_ADDR_W-1:0] addr;
      logic [CTC_DATA_W-1:0] wdata;
   } ctc_mem_req_type;

   // reset values of the request registers
   localparam ctc_cpu_req_type CTC_CPU_REQ_RESET = '0;
   localparam ctc_mem_req_type CTC_MEM_REQ_RESET = '0;

endpackage

/* File: hw/ctc_tag_cmp.sv */
`timescale 1ns/1ps
module ctc_tag_cmp
   import ctc_pkg::*;
#(
   parameter int TAG_W = CTC_TAG_W
) (
   // stored entry
   input wire logic [TAG_W-1:0] stored_tag,
   input wire logic stored_valid,
   // high-order address bits of the access
   input wire logic [TAG_W-1:0] addr_tag,
   // one when the entry holds the addressed line
   output logic match
);

   // equal tag on a filled entry is a hit, anything else a miss
   assign match = stored_valid && (stored_tag == addr_tag);
endmodule

/* File: verif/ctc_props.sv */
`timescale 1ns/1ps
module ctc_props
   import ctc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // processor side
   input wire ctc_cpu_req_type cpu_req,
   input wire logic [CTC_DATA_W-1:0] cpu_rdata,
   input wire logic cpu_done,
   input wire logic cpu_wait,
   input wire logic cpu_match,
   input wire logic init_busy,
   // memory side
   input wire ctc_mem_req_type mem_req,
   input wire logic mem_ack,
   input wire logic [CTC_DATA_W-1:0] mem_rdata
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic [13:0] cyc_reg;
   logic [13:0] cyc_next;
   logic rd_ok;
   // edges since reset release, saturating
   always_comb begin
      cyc_next = (cyc_reg == 14'h3FFF) ? cyc_reg : cyc_reg + 14'h1;
   end
   always_ff @(posedge clock) begin
      cyc_reg <= rstn ? cyc_next : 14'h0;
   end
   assign rd_ok = cpu_req.valid && !cpu_req.write && !cpu_wait;
   AST_INIT_SWEEP: assert property (init_busy == (cyc_reg < 14'h1000))
      else $error("init sweep length wrong");
   AST_READ_RESULT: assert property (
      rd_ok |=> (cpu_done && cpu_match) || (cpu_wait && !cpu_match))
      else $error("read neither hit nor miss");
   AST_MISS_FETCH: assert property (
      rd_ok ##1 !cpu_match |-> mem_req.req && !mem_req.write && mem_req.addr == $past(cpu_req.addr))
      else $error("miss without memory fetch");
   AST_REQ_WAIT: assert property (mem_req.req |-> cpu_wait)
      else $error("memory busy without wait");
   AST_REQ_HOLD: assert property (mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req))
      else $error("memory request dropped early");
   AST_ACK_DONE: assert property (mem_req.req && mem_ack |=> cpu_done && !cpu_wait && !mem_req.req)
      else $error("no completion after ack");
   AST_FILL_DATA: assert property (
      mem_req.req && !mem_req.write && mem_ack |=> cpu_rdata == $past(mem_rdata))
      else $error("fetched data not returned");
   AST_IDLE_QUIET: assert property (!cpu_req.valid && !cpu_wait |=> !cpu_done)
      else $error("done without request");
   cover property (rd_ok ##1 cpu_done && cpu_match);
   cover property (rd_ok ##1 cpu_wait);
   cover property (mem_req.req && mem_req.write && mem_ack);
   cover property (cpu_req.valid && cpu_req.write && !cpu_wait ##1 cpu_match);
endmodule

/* File: verif/ctc_mem_model.sv */
`timescale 1ns/1ps
module ctc_mem_model
   import ctc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // memory port
   input wire ctc_mem_req_type mem_req,
   output logic mem_ack,
   output logic [CTC_DATA_W-1:0] mem_rdata
);
   logic [CTC_DATA_W-1:0] store [logic [CTC_ADDR_W-1:0]];
   int dly = 0;
   // answer after 0..3 idle cycles; data toggles when not acked
   always @(posedge clock) begin
      if (!rstn) begin
         mem_ack <= 1'b0;
         mem_rdata <= 16'h0000;
      end else if (mem_req.req && !mem_ack && dly == 0) begin
         mem_ack <= 1'b1;
         if (mem_req.write) store[mem_req.addr] = mem_req.wdata;
         mem_rdata <= store.exists(mem_req.addr) ? store[mem_req.addr]
            : mem_req.addr[15:0] ^ 16'h5A5A;
         dly <= $urandom_range(3, 0);
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req.req && !mem_ack) dly <= dly - 1;
      end
   end
endmodule

/* File: verif/ctc_cache_tag_controller_tb.sv */
`timescale 1ns/1ps
module ctc_cache_tag_controller_tb
   import ctc_pkg::*;
;
   typedef struct packed {logic rd; logic hit; logic [CTC_DATA_W-1:0] data;} ctc_note_type;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   ctc_cpu_req_type cpu_req = CTC_CPU_REQ_RESET;
   logic [CTC_DATA_W-1:0] cpu_rdata, mem_rdata;
   logic cpu_done, cpu_wait, cpu_match, init_busy, mem_ack;
   ctc_mem_req_type mem_req;
   ctc_note_type notes[$];
   ctc_note_type n;
   logic [CTC_DATA_W-1:0] shadow [logic [CTC_ADDR_W-1:0]];
   logic [CTC_TAG_W-1:0] tags [CTC_SETS][2];
   bit vld [CTC_SETS][2];
   bit mru [CTC_SETS];
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;
   initial begin
      forever #2.5 clock = ~clock;
   end
   ctc_cache_tag_controller #(.WAYS(2)) dut_u (.clock(clock), .rstn(rstn), .cpu_req(cpu_req),
      .cpu_rdata(cpu_rdata), .cpu_done(cpu_done), .cpu_wait(cpu_wait), .cpu_match(cpu_match),
      .init_busy(init_busy), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   ctc_mem_model mem_u (.clock(clock), .rstn(rstn), .mem_req(mem_req), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   task automatic end_of_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // hold a request until taken, then predict hit, victim and data
   task automatic op(input logic w, input logic [CTC_ADDR_W-1:0] a, input logic [15:0] d);
      logic [CTC_INDEX_W-1:0] ix;
      logic hit;
      int way;
      ix = a[CTC_INDEX_W-1:0];
      hit = 1'b0;
      way = 0;
      cpu_req <= '{1'b1, w, a, d};
      @(posedge clock);
      while (cpu_wait !== 1'b0) @(posedge clock);
      for (int i = 0; i < 2; i++) begin
         if (vld[ix][i] && tags[ix][i] == a[CTC_ADDR_W-1:CTC_TAG_LSB]) begin
            hit = 1'b1;
            way = i;
         end
      end
      if (w) begin
         shadow[a] = d;
      end else begin
         if (!hit) begin
            way = !vld[ix][0] ? 0 : !vld[ix][1] ? 1 : int'(!mru[ix]);
            tags[ix][way] = a[CTC_ADDR_W-1:CTC_TAG_LSB];
            vld[ix][way] = 1'b1;
         end
         mru[ix] = way[0];
      end
      notes.push_back('{!w, hit, shadow.exists(a) ? shadow[a] : a[15:0] ^ 16'h5A5A});
   endtask
   // each completion takes the oldest note; cycle ceiling cuts a hang
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
      if (cpu_done === 1'b1) begin
         if (notes.size() == 0) begin
            cmp("spurious done", 16'h0000, 16'h0001);
         end else begin
            n = notes.pop_front();
            cmp("match", {15'h0000, n.hit}, {15'h0000, cpu_match});
            if (n.rd) cmp("read data", n.data, cpu_rdata);
         end
      end
   end
   // writes miss without allocating, then mixed reads and writes over few sets
   initial begin
      logic [31:0] r;
      void'($urandom(3));
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      repeat (40) begin
         r = $urandom;
         op(1'b1, {10'h000, r[1:0], 10'h3C0, r[4:3]}, r[31:16]);
      end
      repeat (300) begin
         r = $urandom;
         op(r[6:5] == 2'b11, {10'h000, r[1:0], r[2] ? 10'h3C0 : 10'h000, r[4:3]},
            r[31:16]);
      end
      cpu_req.valid <= 1'b0;
      repeat (20) @(posedge clock);
      cmp("pending notes", 16'h0000, 16'(notes.size()));
      end_of_test();
   end
endmodule
bind ctc_cache_tag_controller ctc_props chk_u (.clock(clock), .rstn(rstn), .cpu_req(cpu_req),
   .cpu_rdata(cpu_rdata), .cpu_done(cpu_done), .cpu_wait(cpu_wait), .cpu_match(cpu_match),
   .init_busy(init_busy), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
